// file: hex_gate_regs.svh
`ifndef HEX_GATE_REGS_SVH
`define HEX_GATE_REGS_SVH

`define CLK_PERIOD_NS     25
`define OPEN_SENSE_NS     28000
`define SHORT_ON_NS       56000
`define REFRESH_OFF_NS    16400000
// least times round up, the refresh time is kept as a typical figure
`define OPEN_SENSE_CYC    ((`OPEN_SENSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHORT_ON_CYC      ((`SHORT_ON_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_OFF_CYC   (`REFRESH_OFF_NS / `CLK_PERIOD_NS)
`define FRAME_SHORT_BITS  5'h08
`define FRAME_LONG_BITS   5'h10
`define FLAG_BIT          7
`define NUM_CH            6

`endif

// file: hex_gate_pkg.sv
package hex_gate_pkg;
	typedef logic [5:0] chan_mask_t;
	typedef logic [19:0] tick_t;

	typedef struct packed {
		logic       cs_n;
		logic       sck;
		logic       si;
		logic       pwm_override_select;
		logic       pwm_input_ch_zero_one;
		logic       pwm_input_ch_four_five;
		logic       over_voltage;
		chan_mask_t parallel_gate_inputs;
		chan_mask_t drain_above_threshold;
	} pin_in_s;

	typedef enum logic [2:0] {
		MON_NORMAL    = 3'b001,
		MON_RETRY_OFF = 3'b010,
		MON_RETRY_ON  = 3'b100
	} mon_state_e;

	typedef struct packed {
		mon_state_e mode;
		tick_t      cnt;
		logic       short_flt;
		logic       open_flt;
	} mon_state_s;

	typedef struct packed {
		logic       sck_q;
		logic       cs_n_q;
		logic [4:0] bit_cnt;
		logic [7:0] shreg;
		logic       so;
		chan_mask_t cmd;
		chan_mask_t frozen;
		chan_mask_t gate;
	} spi_state_s;
endpackage

// file: pin_sync.sv
`timescale 1ns/1ps
module pin_sync
	import hex_gate_pkg::*;
#(
	parameter int               WIDTH     = 8,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_s;

	sync_s st_ff;
	sync_s nxt_st;

	always_comb
	begin
		nxt_st.meta   = async_i;
		nxt_st.stable = st_ff.meta;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			// both stages leave reset at the pins' idle levels so no false edge follows reset
			st_ff <= '{meta: RESET_VAL, stable: RESET_VAL};
		else
			st_ff <= nxt_st;
	end

	assign sync_o = st_ff.stable;
endmodule

// file: chan_fault_mon.sv
`timescale 1ns/1ps
`include "hex_gate_regs.svh"
module chan_fault_mon
	import hex_gate_pkg::*;
#(
	parameter tick_t SHORT_CYC   = tick_t'(`SHORT_ON_CYC),
	parameter tick_t REFRESH_CYC = tick_t'(`REFRESH_OFF_CYC),
	parameter tick_t OPEN_CYC    = tick_t'(`OPEN_SENSE_CYC)
)(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic request_i,
	input  wire logic gate_on_i,
	input  wire logic drain_high_i,
	output logic      retry_off_o,
	output logic      fault_o
);
	mon_state_s st_ff;
	mon_state_s nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		unique case (st_ff.mode)
			MON_NORMAL:
			begin
				if (gate_on_i)
				begin
					nxt_st.open_flt = 1'b0;
					if (drain_high_i)
					begin
						if (st_ff.cnt >= SHORT_CYC)
						begin
							nxt_st.short_flt = 1'b1;
							nxt_st.mode      = MON_RETRY_OFF;
							nxt_st.cnt       = '0;
						end
						else
							nxt_st.cnt = st_ff.cnt + tick_t'(1);
					end
					else
					begin
						nxt_st.cnt       = '0;
						nxt_st.short_flt = 1'b0;
					end
				end
				else if (!request_i)
				begin
					nxt_st.short_flt = 1'b0;
					if (!drain_high_i)
					begin
						if (st_ff.cnt >= OPEN_CYC)
							nxt_st.open_flt = 1'b1;
						else
							nxt_st.cnt = st_ff.cnt + tick_t'(1);
					end
					else
					begin
						nxt_st.cnt      = '0;
						nxt_st.open_flt = 1'b0;
					end
				end
				else
					nxt_st.cnt = '0;
			end
			MON_RETRY_OFF:
			begin
				if (!request_i)
				begin
					nxt_st.mode      = MON_NORMAL;
					nxt_st.cnt       = '0;
					nxt_st.short_flt = 1'b0;
				end
				else if (st_ff.cnt >= REFRESH_CYC - tick_t'(1))
				begin
					nxt_st.mode = MON_RETRY_ON;
					nxt_st.cnt  = '0;
				end
				else
					nxt_st.cnt = st_ff.cnt + tick_t'(1);
			end
			MON_RETRY_ON:
			begin
				// a short that has gone away ends the retry as soon as the drain drops
				if (!request_i || (gate_on_i && !drain_high_i))
				begin
					nxt_st.mode      = MON_NORMAL;
					nxt_st.cnt       = '0;
					nxt_st.short_flt = 1'b0;
				end
				else if (st_ff.cnt >= SHORT_CYC - tick_t'(1))
				begin
					nxt_st.mode = MON_RETRY_OFF;
					nxt_st.cnt  = '0;
				end
				else
					nxt_st.cnt = st_ff.cnt + tick_t'(1);
			end
			default:
			begin
				nxt_st.mode = MON_NORMAL;
				nxt_st.cnt  = '0;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			st_ff           <= '0;
			st_ff.mode      <= MON_NORMAL;
		end
		else
			st_ff <= nxt_st;
	end

	assign retry_off_o = (st_ff.mode == MON_RETRY_OFF);
	assign fault_o     = st_ff.short_flt | st_ff.open_flt;

	a_no_open_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		gate_on_i |=> !st_ff.open_flt)
		else $error("open load flagged while gate on");

	sequence s_short_seen;
		(st_ff.mode == MON_NORMAL) && gate_on_i && drain_high_i && (st_ff.cnt >= SHORT_CYC);
	endsequence

	a_short_retry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_short_seen |=> (st_ff.short_flt && retry_off_o))
		else $error("short not followed by low duty drive");

	a_refresh_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(retry_off_o && request_i && st_ff.cnt == REFRESH_CYC - tick_t'(1))
		|=> st_ff.mode == MON_RETRY_ON)
		else $error("refresh off time not ended on count");
endmodule

// file: hex_gate_driver.sv
// Functional notes
// - short while on after sense time flags fault
// - retry: on sense time, off refresh time
// - open load only while off, after sense
// - one fault bit per channel, self clearing
// - fault bits frozen while chip select low
// - over-voltage forces every gate low
// - reset holds all gates off
// - command bits 0-5 turn gates on
// - bit 7 flag loaded complemented under override, but output released then, so line reads high
// - faulted channel bit returns inverted
// - long frame: low gates, high faults
// - long frame bit 15 is override flag
// - long frame bit 14 echoed unchanged
// - second received byte equals first sent
// - sample input on sck rise, msb first
// - output changes on sck fall, msb first
// - output driven only when selected, no override
// - feedback returned while next command shifts
// - gate request is serial or parallel
// - override routes pwm inputs, ignores serial
// - refresh off time 16.4 ms
`timescale 1ns/1ps
`include "hex_gate_regs.svh"
module hex_gate_driver
	import hex_gate_pkg::*;
#(
	parameter int SHORT_CYC   = `SHORT_ON_CYC,
	parameter int REFRESH_CYC = `REFRESH_OFF_CYC,
	parameter int OPEN_CYC    = `OPEN_SENSE_CYC
)(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       cs_n_i,
	input  wire logic       sck_i,
	input  wire logic       si_i,
	output logic            so_o,
	output logic            so_oe_o,
	input  wire logic       pwm_override_select_i,
	input  wire logic       pwm_input_ch_zero_one_i,
	input  wire logic       pwm_input_ch_four_five_i,
	input  wire logic       battery_supply_monitor_ovv_i,
	input  wire chan_mask_t parallel_gate_inputs_i,
	input  wire chan_mask_t drain_monitor_inputs_i,
	output chan_mask_t      gate_drive_outputs_o,
	output chan_mask_t      fault_status_o
);
	pin_in_s    pins_raw;
	pin_in_s    pins;
	spi_state_s st_ff;
	spi_state_s nxt_st;
	chan_mask_t req;
	chan_mask_t retry_off;
	chan_mask_t fault_live;
	logic       sck_rise;
	logic       sck_fall;
	logic       cs_fall;
	logic       cs_rise;
	logic [7:0] echo_mask;
	logic       cmd_take;

	// chip select idles high and an off gate shows a high drain; a zero reset would fake a frame start
	localparam pin_in_s PIN_IDLE = '{
		cs_n:                   1'b1,
		sck:                    1'b0,
		si:                     1'b0,
		pwm_override_select:    1'b0,
		pwm_input_ch_zero_one:  1'b0,
		pwm_input_ch_four_five: 1'b0,
		over_voltage:           1'b0,
		parallel_gate_inputs:   6'h00,
		drain_above_threshold:  6'h3F
	};

	assign pins_raw = '{
		cs_n:                   cs_n_i,
		sck:                    sck_i,
		si:                     si_i,
		pwm_override_select:    pwm_override_select_i,
		pwm_input_ch_zero_one:  pwm_input_ch_zero_one_i,
		pwm_input_ch_four_five: pwm_input_ch_four_five_i,
		over_voltage:           battery_supply_monitor_ovv_i,
		parallel_gate_inputs:   parallel_gate_inputs_i,
		drain_above_threshold:  drain_monitor_inputs_i
	};

	pin_sync #(
		.WIDTH    ($bits(pin_in_s)),
		.RESET_VAL(PIN_IDLE)
	) u_sync (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.async_i(pins_raw),
		.sync_o (pins)
	);

	// edges are found on the synchronised copies; sck must stay below a quarter of clk
	assign sck_rise = pins.sck & ~st_ff.sck_q & ~pins.cs_n;
	assign sck_fall = ~pins.sck & st_ff.sck_q & ~pins.cs_n;
	assign cs_fall  = ~pins.cs_n & st_ff.cs_n_q;
	assign cs_rise  = pins.cs_n & ~st_ff.cs_n_q;

	// flag bit complemented under override, faulted channels inverted
	assign echo_mask = {pins.pwm_override_select, 1'b0, st_ff.frozen};

	function automatic chan_mask_t route_req(input pin_in_s p, input chan_mask_t cmd);
		chan_mask_t r;
		r = cmd | p.parallel_gate_inputs;
		if (p.pwm_override_select)
		begin
			r = {p.pwm_input_ch_four_five, p.pwm_input_ch_four_five,
				p.parallel_gate_inputs[3:2],
				p.pwm_input_ch_zero_one, p.pwm_input_ch_zero_one};
		end
		return r;
	endfunction

	assign req = route_req(pins, st_ff.cmd);

	// only whole 8 or 16 bit frames may reach the gates; a cut frame leaves them as they were
	function automatic logic frame_len_ok(input logic [4:0] n);
		return (n == `FRAME_SHORT_BITS) || (n == `FRAME_LONG_BITS);
	endfunction

	// a frame shifted in under override is dropped, else it would reach the gates once override ends
	assign cmd_take = cs_rise & frame_len_ok(st_ff.bit_cnt) & ~pins.pwm_override_select;

	genvar ch;
	generate
		for (ch = 0; ch < `NUM_CH; ch++)
		begin : g_mon
			chan_fault_mon #(
				.SHORT_CYC  (tick_t'(SHORT_CYC)),
				.REFRESH_CYC(tick_t'(REFRESH_CYC)),
				.OPEN_CYC   (tick_t'(OPEN_CYC))
			) u_mon (
				.clk_i       (clk_i),
				.rst_n_i     (rst_n_i),
				.request_i   (req[ch]),
				.gate_on_i   (st_ff.gate[ch]),
				.drain_high_i(pins.drain_above_threshold[ch]),
				.retry_off_o (retry_off[ch]),
				.fault_o     (fault_live[ch])
			);
		end
	endgenerate

	always_comb
	begin
		nxt_st        = st_ff;
		nxt_st.sck_q  = pins.sck;
		nxt_st.cs_n_q = pins.cs_n;

		if (pins.cs_n)
			nxt_st.frozen = fault_live;

		if (cs_fall)
		begin
			// the last frame's low byte goes back out with the fault pattern applied
			nxt_st.shreg   = st_ff.shreg ^ echo_mask;
			nxt_st.so      = st_ff.shreg[`FLAG_BIT] ^ echo_mask[`FLAG_BIT];
			nxt_st.bit_cnt = '0;
		end
		else if (sck_rise)
		begin
			// an 8-bit path lets a 16-bit frame return its first byte second
			nxt_st.shreg = {st_ff.shreg[6:0], pins.si};
			if (st_ff.bit_cnt != 5'h1F)
				nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
		end
		else if (sck_fall)
			nxt_st.so = st_ff.shreg[`FLAG_BIT];

		if (cmd_take)
			nxt_st.cmd = st_ff.shreg[5:0];

		nxt_st.gate = req & ~retry_off & {`NUM_CH{~pins.over_voltage}};
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			st_ff        <= '0;
			st_ff.sck_q  <= 1'b0;
			st_ff.cs_n_q <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end

	assign gate_drive_outputs_o = st_ff.gate;
	assign fault_status_o       = st_ff.frozen;
	assign so_o                 = st_ff.so;
	// the output is released under override, so the pull-up on the wire reads every bit high
	assign so_oe_o              = ~pins.cs_n & ~pins.pwm_override_select;

	a_gate_ovv: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		pins.over_voltage |=> gate_drive_outputs_o == '0)
		else $error("gate driven during over-voltage");

	a_reset_gates: assert property (@(posedge clk_i)
		!rst_n_i |=> gate_drive_outputs_o == '0)
		else $error("gate driven during reset");

	a_fault_freeze: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!pins.cs_n && !cs_fall) |=> $stable(fault_status_o))
		else $error("fault bits changed during transfer");

	a_so_enable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		so_oe_o == (!pins.cs_n && !pins.pwm_override_select))
		else $error("serial output enable wrong");

	a_echo_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cs_fall |=> st_ff.shreg == ($past(st_ff.shreg) ^ {$past(pins.pwm_override_select), 1'b0,
			$past(st_ff.frozen)}))
		else $error("echo byte not complemented by faults");

	sequence s_frame_end_ok;
		cmd_take;
	endsequence

	a_cmd_apply: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_frame_end_ok |=> st_ff.cmd == $past(st_ff.shreg[5:0]))
		else $error("command not applied at frame end");

	a_cmd_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!cmd_take |=> $stable(st_ff.cmd))
		else $error("command changed outside valid frame end");

	a_sample_rise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(sck_rise && !cs_fall) |=> st_ff.shreg[0] == $past(pins.si))
		else $error("input bit not sampled on sck rise");

	a_override_route: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(pins.pwm_override_select && !pins.over_voltage && retry_off == '0)
		|=> gate_drive_outputs_o[1:0] == {2{$past(pins.pwm_input_ch_zero_one)}})
		else $error("override routing of channels 0 and 1 wrong");

	a_override_four: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(pins.pwm_override_select && !pins.over_voltage && retry_off == '0)
		|=> gate_drive_outputs_o[5:4] == {2{$past(pins.pwm_input_ch_four_five)}})
		else $error("override routing of channels 4 and 5 wrong");

	a_override_mid: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(pins.pwm_override_select && !pins.over_voltage && retry_off == '0)
		|=> gate_drive_outputs_o[3:2] == $past(pins.parallel_gate_inputs[3:2]))
		else $error("channels 2 and 3 not following parallel inputs under override");

	a_override_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(cs_rise && pins.pwm_override_select) |=> $stable(st_ff.cmd))
		else $error("serial command taken under override");

	a_override_oe: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		pins.pwm_override_select |-> !so_oe_o)
		else $error("serial output driven under override");

	a_gate_or: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!pins.pwm_override_select && !pins.over_voltage && retry_off == '0)
		|=> gate_drive_outputs_o == ($past(st_ff.cmd) | $past(pins.parallel_gate_inputs)))
		else $error("gate not the or of command and parallel input");

	a_retry_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(retry_off != '0) |=> (gate_drive_outputs_o & $past(retry_off)) == '0)
		else $error("gate driven during refresh off time");

	a_fault_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		pins.cs_n |=> fault_status_o == $past(fault_live))
		else $error("fault bits not following live faults while deselected");

	a_frame_reject: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(cs_rise && !frame_len_ok(st_ff.bit_cnt)) |=> $stable(st_ff.cmd))
		else $error("command taken from a cut frame");

	sequence s_sck_fall_seen;
		sck_fall && !cs_fall;
	endsequence

	a_so_shift: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_sck_fall_seen |=> so_o == $past(st_ff.shreg[7]))
		else $error("serial output not advanced on sck fall");

	a_so_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!sck_fall && !cs_fall) |=> $stable(so_o))
		else $error("serial output changed between sck falls");

	a_so_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cs_fall |=> so_o == ($past(st_ff.shreg[7]) ^ $past(pins.pwm_override_select)))
		else $error("first returned bit not flagged by override");

	a_count_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cs_fall |=> st_ff.bit_cnt == 5'h00)
		else $error("bit count not cleared at frame start");

	a_count_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(sck_rise && !cs_fall && st_ff.bit_cnt != 5'h1F)
		|=> st_ff.bit_cnt == $past(st_ff.bit_cnt) + 5'h01)
		else $error("bit count not stepped on sck rise");

	a_shift_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		pins.cs_n |=> $stable(st_ff.shreg))
		else $error("shift register moved while deselected");
endmodule

// file: spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model
(
	input  wire logic clk_i,
	input  wire logic so_i,
	output logic      cs_n_o,
	output logic      sck_o,
	output logic      si_o
);
	initial
	begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b1;
	end

	// four clocks at 40 MHz make each half of the 200 ns link clock
	task automatic half();
		repeat (4) @(negedge clk_i);
	endtask

	// read data is taken at the rising link edge, while the device holds it
	task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
		rx = 16'h0000;
		sck_o = 1'b0;
		cs_n_o = 1'b0;
		half();
		half();
		for (int i = nbits - 1; i >= 0; i--)
		begin
			si_o = tx[i];
			half();
			sck_o = 1'b1;
			rx = {rx[14:0], so_i};
			half();
			sck_o = 1'b0;
		end
		half();
		cs_n_o = 1'b1;
		// a released data line must not keep showing the last bit
		si_o = ~si_o;
		half();
		half();
	endtask
endmodule

// file: hex_gate_driver_bench.sv
`timescale 1ns/1ps
module hex_gate_driver_bench;
	import hex_gate_pkg::*;
	localparam int SHORT = 20;
	localparam int REFR  = 60;
	localparam int OPEN  = 10;
	logic        clk_i;
	logic        rst_n_i;
	logic        so_o;
	logic        so_oe_o;
	logic        so_line;
	logic        cs_n;
	logic        sck;
	logic        si;
	logic        ovr;
	logic        pw01;
	logic        pw45;
	logic        ovv;
	chan_mask_t  par;
	chan_mask_t  inject;
	chan_mask_t  gate;
	chan_mask_t  fault;
	chan_mask_t  drain;
	logic [15:0] rx;
	int          n_mismatch = 0;
	int          total_checks = 0;
	int          cycles = 0;

	// a healthy load pulls the drain low when on, high when off; inject flips it
	assign drain = ~gate ^ inject;
	// the line carries a pull-up, so an undriven output reads high
	assign so_line = so_oe_o ? so_o : 1'b1;

	hex_gate_driver #(.SHORT_CYC(SHORT), .REFRESH_CYC(REFR), .OPEN_CYC(OPEN)) DUT (
		.clk_i                        (clk_i),
		.rst_n_i                      (rst_n_i),
		.cs_n_i                       (cs_n),
		.sck_i                        (sck),
		.si_i                         (si),
		.so_o                         (so_o),
		.so_oe_o                      (so_oe_o),
		.pwm_override_select_i        (ovr),
		.pwm_input_ch_zero_one_i      (pw01),
		.pwm_input_ch_four_five_i     (pw45),
		.battery_supply_monitor_ovv_i (ovv),
		.parallel_gate_inputs_i       (par),
		.drain_monitor_inputs_i       (drain),
		.gate_drive_outputs_o         (gate),
		.fault_status_o               (fault)
	);

	spi_master_model M (
		.clk_i  (clk_i),
		.so_i   (so_line),
		.cs_n_o (cs_n),
		.sck_o  (sck),
		.si_o   (si)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic wrap_up();
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wait_is(input string what, input bit use_fault, input chan_mask_t exp);
		int k;
		k = 0;
		while (k < 300 && (use_fault ? fault : gate) !== exp)
		begin
			@(negedge clk_i);
			k++;
		end
		check(what, use_fault ? fault : gate, exp);
	endtask

	task automatic phase_len(input logic lvl, input int exp);
		int c;
		c = 0;
		while (gate[1] === lvl && c < 300)
		begin
			@(negedge clk_i);
			c++;
		end
		check("retry phase", 16'(c >= exp - 6 && c <= exp + 6), 16'h0001);
	endtask

	initial
	begin
		rst_n_i = 1'b0;
		ovr = 1'b0;
		pw01 = 1'b0;
		pw45 = 1'b0;
		ovv = 1'b0;
		par = 6'h00;
		inject = 6'h00;
		repeat (6) @(negedge clk_i);
		check("reset gates", gate, 6'h00);
		check("reset faults", fault, 6'h00);
		rst_n_i = 1'b1;
		repeat (4) @(negedge clk_i);
		check("idle drive enable", so_oe_o, 1'b0);
		M.xfer(16'h0015, 8, rx);
		check("first echo", rx, 16'h0000);
		wait_is("gates", 0, 6'h15);
		M.xfer(16'h002A, 8, rx);
		check("echo", rx, 16'h0015);
		wait_is("gates", 0, 6'h2A);
		par = 6'h01;
		wait_is("gates or", 0, 6'h2B);
		par = 6'h00;
		wait_is("gates", 0, 6'h2A);
		inject = 6'h01;
		wait_is("open fault", 1, 6'h01);
		fork
			M.xfer(16'h002A, 8, rx);
			begin
				// starts as the model lowers select; waiting on that edge here would race it
				repeat (10) @(negedge clk_i);
				inject = 6'h00;
				repeat (30) @(negedge clk_i);
				check("frozen fault", fault, 6'h01);
			end
		join
		check("fault echo", rx, 16'h002B);
		wait_is("fault cleared", 1, 6'h00);
		inject = 6'h02;
		wait_is("short off", 0, 6'h28);
		check("short fault", fault, 6'h02);
		phase_len(1'b0, REFR);
		phase_len(1'b1, SHORT);
		inject = 6'h00;
		wait_is("short ends", 0, 6'h2A);
		wait_is("short cleared", 1, 6'h00);
		M.xfer(16'h4015, 16, rx);
		check("long high byte", rx[15:8], 16'h002A);
		check("long low byte", rx[7:0], 16'h0040);
		wait_is("gates long", 0, 6'h15);
		M.xfer(16'h003F, 5, rx);
		repeat (10) @(negedge clk_i);
		check("odd length", gate, 6'h15);
		ovv = 1'b1;
		wait_is("over voltage", 0, 6'h00);
		ovv = 1'b0;
		wait_is("gates", 0, 6'h15);
		ovr = 1'b1;
		pw01 = 1'b1;
		par = 6'h3C;
		wait_is("override", 0, 6'h0F);
		M.xfer(16'h0030, 8, rx);
		check("override line", rx, 16'h00FF);
		pw45 = 1'b1;
		wait_is("override", 0, 6'h3F);
		pw01 = 1'b0;
		wait_is("override", 0, 6'h3C);
		ovr = 1'b0;
		wait_is("override dropped", 0, 6'h3D);
		M.xfer(16'h0015, 8, rx);
		wait_is("after override", 0, 6'h3D);
		wrap_up();
	end
endmodule
